// ### core/aud_extract_pkg.sv
// package: register map, field layout and carrier structs of the audio extraction register bank
package aud_extract_pkg;
	localparam int          ADDR_W        = 6;
	localparam int          DATA_W        = 8;
	// byte offsets
	localparam logic [5:0]  OFS_CONTROL   = 6'h00;
	localparam logic [5:0]  OFS_PRESENCE  = 6'h01;
	localparam logic [5:0]  OFS_STATUS    = 6'h02;
	localparam logic [5:0]  OFS_ERROR     = 6'h04;
	localparam logic [5:0]  OFS_FILL      = 6'h06;
	localparam logic [5:0]  OFS_CLOCK     = 6'h07;
	localparam logic [5:0]  OFS_CS_FIRST  = 6'h10;
	localparam logic [5:0]  OFS_CS_LAST   = 6'h3F;
	localparam int          CS_DEPTH      = 48;
	// control field positions
	localparam int          CTL_ENABLE    = 0;
	localparam int          CTL_PAIR_LO   = 1;
	localparam int          CTL_PAIR_MSB  = 4;
	localparam int          CTL_MUTE      = 5;
	localparam logic [7:0]  CTL_WMASK     = 8'h3F;
	localparam logic [7:0]  CONTROL_RST   = 8'h00;
	// status register: valid flag and defined field mask
	localparam int          STS_VALID     = 7;
	localparam logic [7:0]  STS_MASK      = 8'hFF;
	// error register: counter in 3:0, sticky flags in 7:4
	localparam logic [3:0]  ERR_CNT_MAX   = 4'hF;
	localparam logic [7:0]  CLK_MASK      = 8'h9F;
	localparam logic [7:0]  ZERO_BYTE     = 8'h00;

	// register bus request
	typedef struct packed {
		logic [5:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} bus_req_s;

	// detection results from the embedded-audio parser
	typedef struct packed {
		logic [3:0] group_found;
		logic [3:0] ctrl_found;
		logic [7:0] packet_status;
		logic       ctrl_packet_seen;
		logic       err_count_evt;
		logic [3:0] err_flag_evt;
		logic [7:0] fill_status;
		logic [7:0] clock_status;
		logic       cs_we;
		logic [5:0] cs_waddr;
		logic [7:0] cs_wdata;
	} parser_s;

	// control outputs toward the extraction datapath
	typedef struct packed {
		logic       enable;
		logic [3:0] pair_sel;
		logic       half_sel;
		logic       mute;
	} ctl_out_s;
endpackage : aud_extract_pkg

// ### core/sdi_audio_extract_regs.sv
// module: software register bank of the embedded audio extraction unit
//
// Notes on behaviour
// - control 00h, presence 01h, status 02h, error 04h, fill 06h, clock 07h; others reserved
// - channel status memory, one byte each, occupies offsets 10h to 3Fh
// - control bit 0 enables extraction and its serial output; clear keeps it idle
// - control bits 3:1 pick the channel pair, 000 first through 111 eighth
// - in 3G level A, control bit 4 is the pair select top bit
// - in 3G level B, control bit 4 picks the multiplexed video half
// - control bit 5 high mutes audio output; clearing restores it
// - control bits 7:6 are reserved with no function
// - presence bits 3:0 are read-only detected data group flags
// - presence bit 0 is group one up to bit 3 for group four
// - presence bits 7:4 are read-only detected control packet flags
// - status bits 3:0 mirror low four bits of received active channel field; the code also loads status bits 6:4 from packet_status
// - status bit 7 sets when a control packet is found, validating status
// - error flags stay set until software writes one to clear them
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ns
module sdi_audio_extract_regs
	import aud_extract_pkg::*;
#(
	parameter int CS_WORDS = CS_DEPTH       // channel status bytes
) (
	input  wire logic       mclk,           // 20 MHz register clock
	input  wire logic       sys_rst,        // synchronous reset, active high
	input  wire bus_req_s   bus_req,        // register bus request
	output logic [7:0]      rdata,          // read data, one cycle after read strobe
	input  wire parser_s    parser,         // parser detection results
	input  wire logic       level_b,        // stream is 3G level B
	output ctl_out_s        ctl_out         // control toward the datapath
);

	// module state apart from the channel status memory
	typedef struct packed {
		logic [7:0] control;
		logic [7:0] presence;
		logic [7:0] status;
		logic [3:0] err_cnt;
		logic [3:0] err_flags;
		logic [7:0] rdata;
		ctl_out_s   ctl;
	} state_s;

	state_s     st_r;
	state_s     st_nxt;
	logic [7:0] cs_mem [CS_WORDS];
	logic [7:0] cs_rd;
	logic [5:0] cs_idx;

	// reserved offsets fall through to zero
	function automatic logic in_cs_range(input logic [5:0] a);
		in_cs_range = (a >= OFS_CS_FIRST) && (a <= OFS_CS_LAST);
	endfunction : in_cs_range

	function automatic logic is_write(input bus_req_s r, input logic [5:0] ofs);
		is_write = r.wr && (r.addr == ofs);
	endfunction : is_write

	assign cs_idx = bus_req.addr - OFS_CS_FIRST;
	assign cs_rd  = cs_mem[cs_idx];

	// parser fills the memory; software only reads it
	always_ff @(posedge mclk) begin
		if (parser.cs_we && in_cs_range(parser.cs_waddr)) begin
			cs_mem[6'(parser.cs_waddr - OFS_CS_FIRST)] <= parser.cs_wdata;
		end
	end

	// next state
	always_comb begin
		st_nxt = st_r;
		// only the defined control bits take writes
		if (is_write(bus_req, OFS_CONTROL)) begin
			st_nxt.control = bus_req.wdata & CTL_WMASK;
		end
		st_nxt.presence = {parser.ctrl_found, parser.group_found};
		if (parser.ctrl_packet_seen) begin
			st_nxt.status = (parser.packet_status & STS_MASK) | (8'h01 << STS_VALID);
		end
		// counter clear by a one in any low bit; a new error in the same cycle still counts
		if (is_write(bus_req, OFS_ERROR) && (bus_req.wdata[3:0] != 4'h0)) begin
			st_nxt.err_cnt = 4'h0;
		end
		if (parser.err_count_evt && (st_nxt.err_cnt != ERR_CNT_MAX)) begin
			st_nxt.err_cnt = st_nxt.err_cnt + 4'h1;
		end
		// write-one-to-clear; a flag raised in the clearing cycle survives
		if (is_write(bus_req, OFS_ERROR)) begin
			st_nxt.err_flags = st_r.err_flags & ~bus_req.wdata[7:4];
		end
		st_nxt.err_flags = st_nxt.err_flags | parser.err_flag_evt;
		// read mux
		st_nxt.rdata = ZERO_BYTE;
		if (bus_req.rd) begin
			case (bus_req.addr)
				OFS_CONTROL:  st_nxt.rdata = st_r.control;
				OFS_PRESENCE: st_nxt.rdata = st_r.presence;
				OFS_STATUS:   st_nxt.rdata = st_r.status;
				OFS_ERROR:    st_nxt.rdata = {st_r.err_flags, st_r.err_cnt};
				OFS_FILL:     st_nxt.rdata = parser.fill_status;
				OFS_CLOCK:    st_nxt.rdata = parser.clock_status & CLK_MASK;
				default:      st_nxt.rdata = in_cs_range(bus_req.addr) ? cs_rd : ZERO_BYTE;
			endcase
		end
		// decode control for the datapath
		st_nxt.ctl.enable   = st_r.control[CTL_ENABLE];
		st_nxt.ctl.pair_sel = level_b ? {1'b0, st_r.control[CTL_PAIR_LO +: 3]}
		                              : st_r.control[CTL_PAIR_LO +: 4];
		st_nxt.ctl.half_sel = level_b & st_r.control[CTL_PAIR_MSB];
		st_nxt.ctl.mute     = st_r.control[CTL_MUTE];
	end

	// state register
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st_r         <= '0;
			st_r.control <= CONTROL_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rdata   = st_r.rdata;
	assign ctl_out = st_r.ctl;

endmodule : sdi_audio_extract_regs

// ### verification/sdi_audio_extract_regs_checker.sv
// checker: port assertions of the audio register bank
`timescale 1ns/1ns
module sdi_audio_extract_regs_checker
	import aud_extract_pkg::*;
(
	input wire logic       mclk,    // clock
	input wire logic       sys_rst, // reset
	input wire bus_req_s   bus_req, // bus
	input wire logic [7:0] rdata,   // read data
	input wire parser_s    parser,  // parser
	input wire logic       level_b, // level b
	input wire ctl_out_s   ctl_out  // controls
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// control write, and a status load read back two cycles on with no reload between
	sequence ctl_wr; bus_req.wr && bus_req.addr == OFS_CONTROL; endsequence
	sequence sts_rd; parser.ctrl_packet_seen ##1 !parser.ctrl_packet_seen [*2]
		##0 (bus_req.rd && bus_req.addr == OFS_STATUS); endsequence
	AST_RD_IDLE: assert property (!bus_req.rd |=> rdata == 8'h00)
		else $error("read data not zero");
	AST_ENABLE: assert property (ctl_wr |=> ##1 ctl_out.enable == $past(bus_req.wdata[0], 2))
		else $error("enable wrong");
	AST_MUTE: assert property (ctl_wr |=> ##1 ctl_out.mute == $past(bus_req.wdata[5], 2))
		else $error("mute wrong");
	AST_PAIR_A: assert property (ctl_wr ##0 !level_b ##1 !level_b |=>
		ctl_out.pair_sel == $past(bus_req.wdata[4:1], 2)) else $error("pair wrong");
	AST_HALF_B: assert property (ctl_wr ##0 level_b ##1 level_b |=>
		ctl_out.half_sel == $past(bus_req.wdata[4], 2)) else $error("half wrong");
	AST_RSVD: assert property (bus_req.rd && bus_req.addr inside {6'h03, 6'h05, 6'h08, 6'h09}
		|=> rdata == 8'h00) else $error("reserved not zero");
	AST_PRES: assert property (bus_req.rd && bus_req.addr == OFS_PRESENCE |=>
		rdata == {$past(parser.ctrl_found, 2), $past(parser.group_found, 2)}) else $error("presence");
	AST_STS: assert property (sts_rd |=> rdata == ($past(parser.packet_status, 3) | 8'h80))
		else $error("status wrong");
endmodule : sdi_audio_extract_regs_checker
bind sdi_audio_extract_regs sdi_audio_extract_regs_checker i_checker (.mclk, .sys_rst, .bus_req,
	.rdata, .parser, .level_b, .ctl_out);

// ### verification/sdi_audio_extract_regs_bench.sv
// testbench: register accesses and parser events
`timescale 1ns/1ns
module sdi_audio_extract_regs_bench import aud_extract_pkg::*;;
	logic       mclk = 1'b0;
	logic       sys_rst = 1'b1;
	bus_req_s   bus_req = '0;
	logic [7:0] rdata;
	parser_s    parser = '0;
	logic       level_b = 1'b0;
	ctl_out_s   ctl_out;
	int         fail_count = 0;
	int         checked = 0;
	logic [5:0] rsv [4] = '{6'h03, 6'h05, 6'h08, 6'h09};
	// 50 ns period
	always #25 mclk = ~mclk;
	sdi_audio_extract_regs i_sdi_audio_extract_regs (.mclk(mclk), .sys_rst(sys_rst),
		.bus_req(bus_req), .rdata(rdata), .parser(parser), .level_b(level_b), .ctl_out(ctl_out));
	task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", w, e, g);
		end
	endtask : chk
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge mclk) bus_req <= '{a, d, 1'b1, 1'b0};
		@(posedge mclk) bus_req.wr <= 1'b0;
	endtask : wr
	// data stands only in the cycle after the strobe, so sample just past that edge
	task automatic rd(input logic [5:0] a, input logic [7:0] e, input string w);
		@(posedge mclk) bus_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge mclk) bus_req.rd <= 1'b0;
		#1 chk(w, e, rdata);
	endtask : rd
	// controls lag the register by one more edge
	task automatic ctl(input logic [7:0] d, input logic [6:0] e);
		wr(OFS_CONTROL, d);
		@(posedge mclk) #1 chk("ctl_out", {1'b0, e}, {1'b0, ctl_out});
	endtask : ctl
	task automatic pulse(input logic p, input logic c, input logic [3:0] f);
		@(posedge mclk) {parser.ctrl_packet_seen, parser.err_count_evt, parser.err_flag_evt} <= {p, c, f};
		@(posedge mclk) {parser.ctrl_packet_seen, parser.err_count_evt, parser.err_flag_evt} <= '0;
	endtask : pulse
	task automatic end_of_test;
		if (fail_count == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : end_of_test
	// main sequence
	initial begin
		repeat (20) @(posedge mclk);
		sys_rst <= 1'b0;
		rd(OFS_CONTROL, 8'h00, "control");
		ctl(8'hFF, 7'b1_1111_0_1);
		rd(OFS_CONTROL, 8'h3F, "control");
		level_b <= 1'b1;
		ctl(8'h13, 7'b1_0001_1_0);
		level_b <= 1'b0;
		ctl(8'h1A, 7'b0_1101_0_0);
		ctl(8'h20, 7'b0_0000_0_1);
		parser.group_found <= 4'h5;
		parser.ctrl_found <= 4'hA;
		wr(OFS_PRESENCE, 8'h00);
		rd(OFS_PRESENCE, 8'hA5, "presence");
		parser.packet_status <= 8'h0C;
		pulse(1'b1, 1'b0, 4'h0);
		rd(OFS_STATUS, 8'h8C, "status");
		pulse(1'b0, 1'b1, 4'h2);
		rd(OFS_ERROR, 8'h21, "error");
		wr(OFS_ERROR, 8'h0F);
		rd(OFS_ERROR, 8'h20, "error");
		wr(OFS_ERROR, 8'h20);
		rd(OFS_ERROR, 8'h00, "error");
		foreach (rsv[i]) begin
			wr(rsv[i], 8'hFF);
			rd(rsv[i], 8'h00, "reserved");
		end
		parser.fill_status <= 8'h5A;
		parser.clock_status <= 8'hFF;
		rd(OFS_FILL, 8'h5A, "fill");
		rd(OFS_CLOCK, 8'h9F, "clock");
		// parser fills both ends of the channel status memory, software reads them back
		@(posedge mclk) parser.cs_we <= 1'b1;
		parser.cs_waddr <= OFS_CS_FIRST;
		parser.cs_wdata <= 8'h3C;
		@(posedge mclk) parser.cs_waddr <= OFS_CS_LAST;
		parser.cs_wdata <= 8'hC3;
		@(posedge mclk) parser.cs_we <= 1'b0;
		rd(OFS_CS_FIRST, 8'h3C, "cs_mem");
		rd(OFS_CS_LAST, 8'hC3, "cs_mem");
		rd(6'h0A, 8'h00, "gap");
		end_of_test();
	end
endmodule : sdi_audio_extract_regs_bench
